// ==== logic/lpp_pkg.sv ====
// constants for the low-power polling configuration bank
package lpp_pkg;
   localparam int unsigned NUM_PROG = 8;
   localparam int unsigned NUM_GND = 14;
   localparam int unsigned FRAME_BITS = 32;
   localparam int unsigned DATA_BITS = 24;
   localparam int unsigned ADDR_BITS = 7;
   // frame fields
   localparam int unsigned ADDR_MSB = 31;
   localparam int unsigned ADDR_LSB = 25;
   localparam int unsigned RW_BIT = 24;
   localparam int unsigned DATA_MSB = 23;
   // reply fields
   localparam int unsigned RPL_FAULT_BIT = 23;
   localparam int unsigned RPL_INT_BIT = 22;
   localparam int unsigned RPL_DATA_MSB = 21;
   // register addresses
   localparam logic [6:0] ADDR_PROG_POLL_CUR = 7'h16;
   localparam logic [6:0] ADDR_GND_POLL_CUR = 7'h17;
   localparam logic [6:0] ADDR_PROG_SLOW_POLL = 7'h18;
   localparam logic [7:0] RST_PROG = 8'h00;
   localparam logic [13:0] RST_GND = 14'h0000;
   // slow polling divides the base rate by this factor
   localparam int unsigned SLOW_FACTOR = 4;
   localparam logic [1:0] SLOW_CNT_LAST = 2'h3;
   typedef enum logic [1:0] {LPP_CUR_NORMAL_GND, LPP_CUR_NORMAL_BAT, LPP_CUR_WETTING}
      lpp_cur_t;
endpackage

// ==== logic/lpp_spi_shift.sv ====
// spi slave frame shifter, mode 0, msb first
`timescale 1ns/1ps
module lpp_spi_shift (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk_pin,
   input wire logic cs_n_pin,
   input wire logic mosi_pin,
   output logic miso,
   output logic frame_done,
   output logic [31:0] frame_rx,
   output logic frame_start,
   input wire logic [31:0] reply_word
);
   logic [2:0] s1, s2;
   logic sclk_d, cs_n_d;
   logic [31:0] sh, next_sh, out_sh, next_out_sh;
   logic [5:0] cnt, next_cnt;
   logic [31:0] next_frame_rx;
   logic next_miso;
   logic rise, fall, start, stop;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // idle pin levels: cs high, sclk low, so no false start after reset
         s1 <= 3'h4;
         s2 <= 3'h4;
         sclk_d <= 1'b0;
         cs_n_d <= 1'b1;
      end else begin
         s1 <= {cs_n_pin, sclk_pin, mosi_pin};
         s2 <= s1;
         sclk_d <= s2[1];
         cs_n_d <= s2[2];
      end
   end

   assign rise = s2[1] & ~sclk_d & ~s2[2];
   assign fall = ~s2[1] & sclk_d & ~s2[2];
   assign start = ~s2[2] & cs_n_d;
   assign stop = s2[2] & ~cs_n_d;
   assign frame_start = start;

   always_comb begin
      next_sh = sh;
      next_cnt = cnt;
      next_out_sh = out_sh;
      next_miso = miso;
      next_frame_rx = frame_rx;
      frame_done = 1'b0;
      if (start) begin
         next_cnt = 6'h00;
         next_out_sh = reply_word;
         next_miso = reply_word[31];
      end else if (rise) begin
         next_sh = {sh[30:0], s2[0]};
         next_cnt = cnt + 6'h01;
      end else if (fall) begin
         next_out_sh = {out_sh[30:0], 1'b0};
         next_miso = out_sh[30];
      end
      // only a count of 32 edges counts; short frames are dropped, long ones too unless the 6-bit count wraps back to 32 (96 bits)
      if (stop && cnt == 6'(lpp_pkg::FRAME_BITS)) begin
         frame_done = 1'b1;
         next_frame_rx = sh;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sh <= 32'h0000_0000;
         cnt <= 6'h00;
         out_sh <= 32'h0000_0000;
         miso <= 1'b0;
         frame_rx <= 32'h0000_0000;
      end else begin
         sh <= next_sh;
         cnt <= next_cnt;
         out_sh <= next_out_sh;
         miso <= next_miso;
         frame_rx <= next_frame_rx;
      end
   end
endmodule

// ==== logic/lpp_config.sv ====
// low-power polling configuration registers with spi access
// Functional notes
// - bit 0 on programmable channel: normal current, battery 2.2 mA, ground 1.0 mA
// - bit 1 on programmable channel: use its programmed wetting current
// - each programmable channel has its own current select bit
// - bit 0 on ground channel: normal 1.0 mA polling current
// - bit 1 on ground channel: use its programmed wetting current
// - base polling rate comes from outside; slow bits only modify it
// - slow bit 1 polls the programmable input four times slower
// - register 0x16 holds programmable current bits 7..0, read-write
// - register 0x17 holds ground current bits 13..0, read-write
// - register 0x18 holds programmable slow bits 7..0, reset zero
// - reply: fault bit 23, interrupt bit 22, register data 21..0
`timescale 1ns/1ps
module lpp_config (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk_pin,
   input wire logic cs_n_pin,
   input wire logic mosi_pin,
   output logic miso,
   input wire logic fault_summary,
   input wire logic int_flag,
   input wire logic [7:0] prog_is_battery,
   input wire logic poll_tick,
   output lpp_pkg::lpp_cur_t prog_cur_sel [8],
   output lpp_pkg::lpp_cur_t gnd_cur_sel [14],
   output logic [7:0] prog_poll_now,
   output logic [13:0] gnd_poll_now,
   output logic [7:0] prog_poll_current_reg,
   output logic [13:0] gnd_poll_current_reg,
   output logic [7:0] prog_slow_poll_reg
);
   logic frame_done;
   logic [31:0] frame_rx;
   logic [31:0] reply_word;
   logic [6:0] last_addr, next_last_addr;
   logic [7:0] next_prog_cur;
   logic [13:0] next_gnd_cur;
   logic [7:0] next_prog_slow;
   logic [21:0] reg_data;
   logic [1:0] slow_cnt, next_slow_cnt;
   logic [6:0] f_addr;
   logic f_write;
   logic [23:0] f_data;

   lpp_spi_shift u_shift (
      .clk(clk),
      .rst(rst),
      .sclk_pin(sclk_pin),
      .cs_n_pin(cs_n_pin),
      .mosi_pin(mosi_pin),
      .miso(miso),
      .frame_done(frame_done),
      .frame_rx(frame_rx),
      .frame_start(),
      .reply_word(reply_word)
   );

   // fields of the received frame
   // frame field split
   assign f_addr = frame_rx[lpp_pkg::ADDR_MSB:lpp_pkg::ADDR_LSB];
   assign f_write = frame_rx[lpp_pkg::RW_BIT];
   assign f_data = frame_rx[lpp_pkg::DATA_MSB:0];

   // decode uses the sampled frame; frame_rx updates with frame_done
   logic pend, next_pend;

   always_comb begin
      next_prog_cur = prog_poll_current_reg;
      next_gnd_cur = gnd_poll_current_reg;
      next_prog_slow = prog_slow_poll_reg;
      next_last_addr = last_addr;
      next_pend = frame_done;
      if (pend) begin
         next_last_addr = f_addr;
         if (f_write) begin
            unique case (f_addr)
               lpp_pkg::ADDR_PROG_POLL_CUR: next_prog_cur = f_data[7:0];
               lpp_pkg::ADDR_GND_POLL_CUR: next_gnd_cur = f_data[13:0];
               lpp_pkg::ADDR_PROG_SLOW_POLL: next_prog_slow = f_data[7:0];
               default: next_last_addr = f_addr;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prog_poll_current_reg <= lpp_pkg::RST_PROG;
         gnd_poll_current_reg <= lpp_pkg::RST_GND;
         prog_slow_poll_reg <= lpp_pkg::RST_PROG;
         last_addr <= 7'h00;
         pend <= 1'b0;
      end else begin
         prog_poll_current_reg <= next_prog_cur;
         gnd_poll_current_reg <= next_gnd_cur;
         prog_slow_poll_reg <= next_prog_slow;
         last_addr <= next_last_addr;
         pend <= next_pend;
      end
   end

   // reply of a frame carries the register addressed by the previous frame;
   // a serial slave cannot know the address before it has been shifted in
   always_comb begin
      reg_data = 22'h000000;
      unique case (last_addr)
         lpp_pkg::ADDR_PROG_POLL_CUR: reg_data = {14'h0000, prog_poll_current_reg};
         lpp_pkg::ADDR_GND_POLL_CUR: reg_data = {8'h00, gnd_poll_current_reg};
         lpp_pkg::ADDR_PROG_SLOW_POLL: reg_data = {14'h0000, prog_slow_poll_reg};
         default: reg_data = 22'h000000;
      endcase
   end

   assign reply_word = {8'h00, fault_summary, int_flag, reg_data};

   // base rate tick from the low-power timer
   always_comb begin
      next_slow_cnt = slow_cnt;
      if (poll_tick) begin
         next_slow_cnt = (slow_cnt == lpp_pkg::SLOW_CNT_LAST) ? 2'h0 : slow_cnt + 2'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slow_cnt <= 2'h0;
      end else begin
         slow_cnt <= next_slow_cnt;
      end
   end

   genvar i;
   generate
      for (i = 0; i < lpp_pkg::NUM_PROG; i++) begin : g_prog
         assign prog_cur_sel[i] = prog_poll_current_reg[i] ? lpp_pkg::LPP_CUR_WETTING :
            (prog_is_battery[i] ? lpp_pkg::LPP_CUR_NORMAL_BAT : lpp_pkg::LPP_CUR_NORMAL_GND);
         assign prog_poll_now[i] = poll_tick &
            (~prog_slow_poll_reg[i] | (slow_cnt == 2'h0));
      end
      for (i = 0; i < lpp_pkg::NUM_GND; i++) begin : g_gnd
         assign gnd_cur_sel[i] = gnd_poll_current_reg[i] ? lpp_pkg::LPP_CUR_WETTING :
            lpp_pkg::LPP_CUR_NORMAL_GND;
         assign gnd_poll_now[i] = poll_tick;
      end
   endgenerate
endmodule

// ==== tb/lpp_props.sv ====
// assertions on the polling configuration bank ports
`timescale 1ns/1ps
module lpp_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n_pin,
   input wire logic [7:0] prog_is_battery,
   input wire logic poll_tick,
   input lpp_pkg::lpp_cur_t prog_cur_sel [8],
   input lpp_pkg::lpp_cur_t gnd_cur_sel [14],
   input wire logic [7:0] prog_poll_now,
   input wire logic [13:0] gnd_poll_now,
   input wire logic [7:0] prog_poll_current_reg,
   input wire logic [13:0] gnd_poll_current_reg,
   input wire logic [7:0] prog_slow_poll_reg
);
   localparam lpp_pkg::lpp_cur_t W = lpp_pkg::LPP_CUR_WETTING;
   localparam lpp_pkg::lpp_cur_t NG = lpp_pkg::LPP_CUR_NORMAL_GND;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_frame_open;
      !cs_n_pin [*6];
   endsequence
   a_prog_wet_sel: assert property (prog_poll_current_reg[3] |-> prog_cur_sel[3] == W)
      else $error("prog wet select");
   a_prog_bat_norm: assert property (!prog_poll_current_reg[2] && prog_is_battery[2]
      |-> prog_cur_sel[2] == lpp_pkg::LPP_CUR_NORMAL_BAT) else $error("prog battery select");
   a_chan_indep: assert property (prog_poll_current_reg[1:0] == 2'h1
      |-> prog_cur_sel[0] == W && prog_cur_sel[1] != W) else $error("select not per channel");
   a_gnd_norm_sel: assert property (!gnd_poll_current_reg[0] |-> gnd_cur_sel[0] == NG)
      else $error("gnd normal select");
   a_gnd_wet_sel: assert property (gnd_poll_current_reg[13] |-> gnd_cur_sel[13] == W)
      else $error("gnd wet select");
   a_gnd_base_rate: assert property (gnd_poll_now == {14{poll_tick}})
      else $error("gnd poll rate");
   a_fast_poll: assert property (!prog_slow_poll_reg[1] |-> prog_poll_now[1] == poll_tick)
      else $error("fast poll rate");
   a_regs_hold: assert property (s_frame_open |-> $stable(prog_poll_current_reg)
      && $stable(gnd_poll_current_reg) && $stable(prog_slow_poll_reg)) else $error("reg moved");
endmodule
bind lpp_config lpp_props u_props (.clk, .rst, .cs_n_pin, .prog_is_battery, .poll_tick,
   .prog_cur_sel, .gnd_cur_sel, .prog_poll_now, .gnd_poll_now, .prog_poll_current_reg,
   .gnd_poll_current_reg, .prog_slow_poll_reg);

// ==== tb/lpp_spi_master.sv ====
// spi master model, mode 0, sclk idles low between frames
`timescale 1ns/1ps
module lpp_spi_master (
   input wire logic clk,
   input wire logic miso,
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
      cs_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         mosi = tx[i];
         repeat (5) @(negedge clk);
         rx[i] = miso;
         sclk = 1'b1;
         repeat (5) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (5) @(negedge clk);
      cs_n = 1'b1;
      // stale data must not look valid
      mosi = ~mosi;
      repeat (8) @(negedge clk);
   endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the polling configuration bank
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sclk, cs_n, mosi, miso, fault, intf, tick;
   logic [7:0] bat = 8'h0F;
   lpp_pkg::lpp_cur_t psel [8];
   lpp_pkg::lpp_cur_t gsel [14];
   logic [7:0] pnow, preg, sreg;
   logic [13:0] gnow, greg;
   logic [31:0] rx;
   int num_errors = 0;
   int n_compared = 0;
   int cnt [8];
   always #2.5 clk = ~clk;
   lpp_spi_master m (.clk, .miso, .sclk, .cs_n, .mosi);
   lpp_config dut (.clk, .rst, .sclk_pin(sclk), .cs_n_pin(cs_n), .mosi_pin(mosi), .miso,
      .fault_summary(fault), .int_flag(intf), .prog_is_battery(bat), .poll_tick(tick),
      .prog_cur_sel(psel), .gnd_cur_sel(gsel), .prog_poll_now(pnow), .gnd_poll_now(gnow),
      .prog_poll_current_reg(preg), .gnd_poll_current_reg(greg), .prog_slow_poll_reg(sreg));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out;
      if (num_errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // reply comes one frame late, so a filler frame fetches it
   task automatic rd(input logic [6:0] a, input logic [21:0] exp);
      m.xfer({a, 1'b0, 24'h000000}, rx);
      m.xfer({7'h00, 1'b0, 24'h000000}, rx);
      chk("reply", rx, {8'h00, fault, intf, exp});
   endtask
   task automatic sel_chk(input logic [7:0] p, input logic [13:0] g);
      for (int i = 0; i < 8; i++)
         chk("prog_sel", psel[i], p[i] ? lpp_pkg::LPP_CUR_WETTING : bat[i] ?
            lpp_pkg::LPP_CUR_NORMAL_BAT : lpp_pkg::LPP_CUR_NORMAL_GND);
      for (int i = 0; i < 14; i++)
         chk("gnd_sel", gsel[i], g[i] ? lpp_pkg::LPP_CUR_WETTING :
            lpp_pkg::LPP_CUR_NORMAL_GND);
   endtask
   initial begin
      #300000;
      num_errors++;
      close_out();
   end
   initial begin
      fault = 1'b0;
      intf = 1'b0;
      tick = 1'b0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      rd(lpp_pkg::ADDR_PROG_POLL_CUR, 22'h000000);
      rd(lpp_pkg::ADDR_GND_POLL_CUR, 22'h000000);
      rd(lpp_pkg::ADDR_PROG_SLOW_POLL, 22'h000000);
      sel_chk(8'h00, 14'h0000);
      m.xfer({lpp_pkg::ADDR_PROG_POLL_CUR, 1'b1, 24'hFFFFA5}, rx);
      m.xfer({lpp_pkg::ADDR_GND_POLL_CUR, 1'b1, 24'hFFE001}, rx);
      m.xfer({lpp_pkg::ADDR_PROG_SLOW_POLL, 1'b1, 24'hFFFF81}, rx);
      m.xfer({7'h19, 1'b1, 24'hFFFFFF}, rx);
      fault = 1'b1;
      rd(lpp_pkg::ADDR_PROG_POLL_CUR, 22'h0000A5);
      fault = 1'b0;
      intf = 1'b1;
      rd(lpp_pkg::ADDR_GND_POLL_CUR, 22'h002001);
      rd(lpp_pkg::ADDR_PROG_SLOW_POLL, 22'h000081);
      rd(7'h19, 22'h000000);
      chk("prog_reg", preg, 32'h000000A5);
      chk("gnd_reg", greg, 32'h00002001);
      chk("slow_reg", sreg, 32'h00000081);
      sel_chk(8'hA5, 14'h2001);
      cnt = '{default: 0};
      // sample before the edge that advances the slow counter
      repeat (8) begin
         tick = 1'b1;
         #1;
         for (int i = 0; i < 8; i++) cnt[i] += pnow[i];
         chk("gnd_now", gnow, 32'h00003FFF);
         @(negedge clk);
         tick = 1'b0;
         repeat (2) @(negedge clk);
      end
      for (int i = 0; i < 8; i++) chk("polls", cnt[i], (i == 0 || i == 7) ? 2 : 8);
      // mid-run reset must clear every register
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk("prog_reg", preg, 32'h00000000);
      chk("gnd_reg", greg, 32'h00000000);
      chk("slow_reg", sreg, 32'h00000000);
      rd(lpp_pkg::ADDR_PROG_SLOW_POLL, 22'h000000);
      close_out();
   end
endmodule
